// ==== design/mask_cr_pkg.sv ====
// package with encodings, offsets, masks and carrier types of the mask and condition-field unit
package mask_cr_pkg;

	localparam int XLEN = 32;

	// opcodes
	localparam logic [5:0] OP_FIXED     = 6'h1F;
	localparam logic [5:0] OP_COND      = 6'h13;
	localparam logic [5:0] OP_FLOAT     = 6'h3F;
	localparam logic [9:0] XO_MASK_GEN  = 10'h01D;
	localparam logic [9:0] XO_MASK_INS  = 10'h21D;
	localparam logic [9:0] XO_CR_COPY   = 10'h000;
	localparam logic [9:0] XO_FS_COPY   = 10'h040;

	// register offsets on the bus (byte addresses)
	localparam logic [7:0] OFS_COND_REG = 8'h00;
	localparam logic [7:0] OFS_FP_STAT  = 8'h04;
	localparam logic [7:0] OFS_FX_EXC   = 8'h08;
	localparam logic [7:0] OFS_OP_COUNT = 8'h0C;

	// reset values
	localparam logic [31:0] RST_COND_REG = 32'h0000_0000;
	localparam logic [31:0] RST_FP_STAT  = 32'h0000_0000;
	localparam logic [31:0] RST_FX_EXC   = 32'h0000_0000;

	// bit position counted from the lsb of the vector, then field width and field count
	localparam int SUMMARY_OVF_BIT = 31;
	localparam int FIELD_W         = 4;
	localparam int NUM_FIELDS      = 8;

	// reserved bit positions of the fp status register read as zero when copied
	localparam logic [31:0] FS_RESERVED = 32'h0000_0800;

	// exception bits cleared by the status-to-condition copy, indexed by source field
	localparam logic [7:0][31:0] FS_CLEAR = {
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0008_0000, 32'h00F0_0000, 32'h0F00_0000, 32'h9000_0000
	};

	// fixed-point form of the instruction word, msb first
	typedef struct packed {
		logic [5:0] primary;
		logic [4:0] first_source_sel;
		logic [4:0] target_sel;
		logic [4:0] second_source_sel;
		logic [9:0] ext;
		logic       record_flag;
	} fixed_form_t;

	// condition-field form of the instruction word, msb first
	typedef struct packed {
		logic [5:0] primary;
		logic [2:0] dest_cond_field_sel;
		logic [1:0] unused_a;
		logic [2:0] src_field_sel;
		logic [1:0] unused_b;
		logic [4:0] unused_c;
		logic [9:0] ext;
		logic       unused_d;
	} field_form_t;

	// whole state of the unit
	typedef struct packed {
		logic [31:0] cond_reg;
		logic [31:0] fp_stat;
		logic [31:0] fx_exc;
		logic [31:0] op_count;
		logic [31:0] rd_data;
		logic        ack;
		logic        wr_valid;
		logic [4:0]  wr_sel;
		logic [31:0] wr_data;
		logic        illegal;
	} unit_state_t;

endpackage

// ==== design/mask_and_cr_field_unit.sv ====
// mask generate/insert and condition-field move execution unit with a wishbone register slave
// Function
// (RQ1) mask generate: start from low five bits of first source, end from second.
// (RQ2) start below end plus one: ones from start through end, zeros elsewhere.
// (RQ3) start equal to end plus one: all 32 mask bits set.
// (RQ4) start above end plus one: zeros from end+1 to start-1, ones elsewhere.
// (RQ5) mask insert: target bit takes source bit where mask bit is one.
// (RQ6) mask insert: target bit keeps old value where mask bit is zero.
// (RQ7) mask operations never change the fixed-point exception register.
// (RQ8) record flag set updates field 0 with sign flags and summary overflow.
// (RQ9) mask insert decodes as primary 31, extended 541, record flag lowest bit.
// (RQ10) condition-field copy moves the source field into the destination field.
// (RQ11) condition-field copy leaves other fields and exception register unchanged.
// (RQ12) status copy moves selected fp status field into destination condition field.
// (RQ13) reserved fp status bits are supplied as zeros in the copied value.
// (RQ14) status copy source selector addresses one of eight fields, 0 to 7.
// (RQ15) status copy clears the exception bits of the copied field.
// (RQ16) mask generate decodes as primary 31, extended 29, record flag lowest bit.
// (RQ17) opcodes and 3-bit field selectors are decoded from the instruction word.
module mask_and_cr_field_unit
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        instr_valid_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] first_source_i,
	input  wire logic [31:0] second_source_i,
	input  wire logic [31:0] target_old_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wr_valid_o,
	output logic      [4:0]  wr_sel_o,
	output logic      [31:0] wr_data_o,
	output logic             illegal_o,
	output logic      [31:0] cond_reg_o,
	output logic      [31:0] fp_stat_o
);

	mask_cr_pkg::unit_state_t st_r;
	mask_cr_pkg::unit_state_t st_nxt;

	mask_cr_pkg::fixed_form_t fx_form;
	mask_cr_pkg::field_form_t fd_form;

	logic [5:0]  start_pos;
	logic [5:0]  end_pos;
	logic [31:0] gen_mask;
	logic [31:0] ins_result;

	assign fx_form = mask_cr_pkg::fixed_form_t'(instr_i); // RQ17
	assign fd_form = mask_cr_pkg::field_form_t'(instr_i); // RQ17

	assign start_pos = {1'b0, first_source_i[4:0]};  // RQ1
	assign end_pos   = {1'b0, second_source_i[4:0]}; // RQ1

	// mask bit k of the architected numbering sits at vector bit 31-k
	genvar k;
	generate
		for (k = 0; k < mask_cr_pkg::XLEN; k++)
		begin : g_mask
			localparam logic [5:0] POS = 6'(k);
			always_comb
			begin
				if (start_pos < end_pos + 6'h01)
					gen_mask[31 - k] = (POS >= start_pos) && (POS <= end_pos); // RQ2
				else if (start_pos == end_pos + 6'h01)
					gen_mask[31 - k] = 1'b1; // RQ3
				else
					gen_mask[31 - k] = !((POS >= end_pos + 6'h01) && (POS <= start_pos - 6'h01)); // RQ4
			end
		end
	endgenerate

	assign ins_result = (first_source_i & second_source_i) | (target_old_i & ~second_source_i); // RQ5 RQ6

	// byte-lane merge of a bus write into a register
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return res;
	endfunction

	// field n of a 32-bit register, field 0 in the top nibble
	function automatic logic [3:0] get_field(input logic [31:0] v, input logic [2:0] n);
		return v[(3'd7 - n) * 4 +: 4];
	endfunction

	function automatic logic [31:0] put_field(input logic [31:0] v, input logic [2:0] n,
		input logic [3:0] f);
		logic [31:0] res;
		res = v;
		res[(3'd7 - n) * 4 +: 4] = f;
		return res;
	endfunction

	always_comb
	begin
		logic        bus_req;
		logic        is_mask;
		logic [31:0] result;
		logic [3:0]  cr0;
		logic [3:0]  fs_field;
		bus_req  = wb_cyc_i && wb_stb_i && !st_r.ack;
		is_mask  = 1'b0;
		result   = 32'h0000_0000;
		cr0      = 4'h0;
		fs_field = 4'h0;
		st_nxt   = st_r;
		st_nxt.ack      = 1'b0;
		st_nxt.wr_valid = 1'b0;
		st_nxt.illegal  = 1'b0;

		// ack one cycle after the request; the second cycle sees ack high and stays quiet
		if (bus_req)
		begin
			st_nxt.ack = 1'b1;
			case (wb_adr_i)
				mask_cr_pkg::OFS_COND_REG: st_nxt.rd_data = st_r.cond_reg;
				mask_cr_pkg::OFS_FP_STAT:  st_nxt.rd_data = st_r.fp_stat;
				mask_cr_pkg::OFS_FX_EXC:   st_nxt.rd_data = st_r.fx_exc;
				mask_cr_pkg::OFS_OP_COUNT: st_nxt.rd_data = st_r.op_count;
				default:                   st_nxt.rd_data = 32'h0000_0000;
			endcase
			if (wb_we_i)
			begin
				case (wb_adr_i)
					mask_cr_pkg::OFS_COND_REG:
						st_nxt.cond_reg = lane_merge(st_r.cond_reg, wb_dat_i, wb_sel_i);
					mask_cr_pkg::OFS_FP_STAT:
						st_nxt.fp_stat = lane_merge(st_r.fp_stat, wb_dat_i, wb_sel_i);
					mask_cr_pkg::OFS_FX_EXC:
						st_nxt.fx_exc = lane_merge(st_r.fx_exc, wb_dat_i, wb_sel_i);
					default:
						st_nxt.rd_data = st_nxt.rd_data;
				endcase
			end
		end

		// an instruction in the same cycle as a bus write wins on the bits it touches
		if (instr_valid_i)
		begin
			st_nxt.op_count = st_r.op_count + 32'h0000_0001;
			if (fx_form.primary == mask_cr_pkg::OP_FIXED && fx_form.ext == mask_cr_pkg::XO_MASK_GEN) // RQ16
			begin
				is_mask = 1'b1;
				result  = gen_mask; // RQ1
			end
			else if (fx_form.primary == mask_cr_pkg::OP_FIXED && fx_form.ext == mask_cr_pkg::XO_MASK_INS) // RQ9
			begin
				is_mask = 1'b1;
				result  = ins_result; // RQ5 RQ6
			end
			else if (fd_form.primary == mask_cr_pkg::OP_COND && fd_form.ext == mask_cr_pkg::XO_CR_COPY)
			begin
				// only the destination field is written; exception register untouched
				st_nxt.cond_reg = put_field(st_nxt.cond_reg, fd_form.dest_cond_field_sel,
					get_field(st_nxt.cond_reg, fd_form.src_field_sel)); // RQ10 RQ11
			end
			else if (fd_form.primary == mask_cr_pkg::OP_FLOAT && fd_form.ext == mask_cr_pkg::XO_FS_COPY)
			begin
				fs_field = get_field(st_nxt.fp_stat & ~mask_cr_pkg::FS_RESERVED, fd_form.src_field_sel); // RQ13 RQ14
				st_nxt.cond_reg = put_field(st_nxt.cond_reg, fd_form.dest_cond_field_sel, fs_field); // RQ12
				st_nxt.fp_stat  = st_nxt.fp_stat & ~mask_cr_pkg::FS_CLEAR[fd_form.src_field_sel]; // RQ15
			end
			else
			begin
				st_nxt.illegal = 1'b1;
			end

			// mask results go back to the register file; exception register is left alone
			if (is_mask)
			begin
				st_nxt.wr_valid = 1'b1; // RQ7
				st_nxt.wr_sel   = fx_form.target_sel;
				st_nxt.wr_data  = result;
				if (fx_form.record_flag)
				begin
					cr0[3] = result[31];
					cr0[2] = !result[31] && (result != 32'h0000_0000);
					cr0[1] = (result == 32'h0000_0000);
					cr0[0] = st_nxt.fx_exc[mask_cr_pkg::SUMMARY_OVF_BIT];
					st_nxt.cond_reg = put_field(st_nxt.cond_reg, 3'd0, cr0); // RQ8
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r          <= '0;
			st_r.cond_reg <= mask_cr_pkg::RST_COND_REG;
			st_r.fp_stat  <= mask_cr_pkg::RST_FP_STAT;
			st_r.fx_exc   <= mask_cr_pkg::RST_FX_EXC;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign wb_dat_o   = st_r.rd_data;
	assign wb_ack_o   = st_r.ack;
	assign wr_valid_o = st_r.wr_valid;
	assign wr_sel_o   = st_r.wr_sel;
	assign wr_data_o  = st_r.wr_data;
	assign illegal_o  = st_r.illegal;
	assign cond_reg_o = st_r.cond_reg;
	assign fp_stat_o  = st_r.fp_stat;

endmodule

// ==== verif/mask_cr_monitor.sv ====
// checker of result timing and values at the unit's ports
module mask_cr_monitor
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] first_source_i,
	input wire logic [31:0] second_source_i,
	input wire logic [31:0] target_old_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        wr_valid_o,
	input wire logic [4:0]  wr_sel_o,
	input wire logic [31:0] wr_data_o,
	input wire logic        illegal_o,
	input wire logic [31:0] cond_reg_o,
	input wire logic [31:0] fp_stat_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_op(logic [5:0] op, logic [9:0] xo);
		instr_valid_i && instr_i[31:26] == op && instr_i[10:1] == xo;
	endsequence
	sequence s_gen;
		s_op(mask_cr_pkg::OP_FIXED, mask_cr_pkg::XO_MASK_GEN);
	endsequence
	sequence s_ins;
		s_op(mask_cr_pkg::OP_FIXED, mask_cr_pkg::XO_MASK_INS);
	endsequence
	// a bus write in the same cycle also moves the registers, so those cycles are left out
	sequence s_crc;
		s_op(mask_cr_pkg::OP_COND, mask_cr_pkg::XO_CR_COPY) ##0 !wb_stb_i;
	endsequence
	sequence s_fsc;
		s_op(mask_cr_pkg::OP_FLOAT, mask_cr_pkg::XO_FS_COPY) ##0 !wb_stb_i;
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_mask_wb: assert property ((s_gen or s_ins) |=> wr_valid_o && wr_sel_o == $past(instr_i[20:16]))
		else $error("mask result not written back");
	a_full_mask: assert property (s_gen ##0 ({1'b0, first_source_i[4:0]} == second_source_i[4:0] + 6'd1)
		|=> wr_data_o == 32'hFFFF_FFFF)
		else $error("full mask wrong");
	a_insert_bits: assert property (s_ins |=> wr_data_o == ($past(first_source_i) & $past(second_source_i) |
		$past(target_old_i) & ~$past(second_source_i)))
		else $error("insert result wrong");
	a_no_record: assert property ((s_gen or s_ins) ##0 (!instr_i[0] && !wb_stb_i) |=> $stable(cond_reg_o))
		else $error("condition changed without record");
	a_field_copy: assert property (s_crc |=> 4'(cond_reg_o >> (28 - 4 * $past(instr_i[25:23]))) ==
		4'($past(cond_reg_o) >> (28 - 4 * $past(instr_i[20:18]))))
		else $error("field copy wrong");
	a_stat_copy: assert property (s_fsc |=> 4'(cond_reg_o >> (28 - 4 * $past(instr_i[25:23]))) ==
		4'(($past(fp_stat_o) & ~mask_cr_pkg::FS_RESERVED) >> (28 - 4 * $past(instr_i[20:18]))))
		else $error("status copy wrong");
	a_stat_clear: assert property (s_fsc |=> fp_stat_o == ($past(fp_stat_o) &
		~mask_cr_pkg::FS_CLEAR[$past(instr_i[20:18])]))
		else $error("status bits not cleared");
	a_pulse_cause: assert property (wr_valid_o || illegal_o |-> $past(instr_valid_i))
		else $error("result pulse without issue");
endmodule

bind mask_and_cr_field_unit mask_cr_monitor mon_u (.clk_i, .rst_i, .instr_valid_i, .instr_i, .first_source_i,
	.second_source_i, .target_old_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wr_valid_o, .wr_sel_o, .wr_data_o,
	.illegal_o, .cond_reg_o, .fp_stat_o);

// ==== verif/gpr_model.sv ====
// register file model feeding operands and taking mask results back
module gpr_model
(
	input  wire logic        clk_i,
	input  wire logic [31:0] instr_i,
	input  wire logic        wr_valid_i,
	input  wire logic [4:0]  wr_sel_i,
	input  wire logic [31:0] wr_data_i,
	output logic      [31:0] first_o,
	output logic      [31:0] second_o,
	output logic      [31:0] target_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] regs [32];
	initial foreach (regs[i]) regs[i] = 32'h0000_0000;
	assign first_o  = regs[instr_i[25:21]];
	assign second_o = regs[instr_i[15:11]];
	assign target_o = regs[instr_i[20:16]];
	always @(posedge clk_i)
		if (wr_valid_i)
			regs[wr_sel_i] <= wr_data_i;
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the mask and condition-field unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] instr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, wr_data_o, cond_reg_o, fp_stat_o, a_w, b_w, t_w;
	logic [31:0] q, a, b, g, cr, fs;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [4:0]  wr_sel_o;
	logic [2:0]  d;
	logic        wb_ack_o, wr_valid_o, illegal_o;
	int          miscompares = 0, n_tests = 0, seed = 91821, n_ops = 0;
	always #2.5 clk_i = ~clk_i;
	mask_and_cr_field_unit dut_u (.clk_i, .rst_i, .instr_valid_i, .instr_i, .first_source_i(a_w),
		.second_source_i(b_w), .target_old_i(t_w), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .wr_valid_o, .wr_sel_o, .wr_data_o, .illegal_o, .cond_reg_o, .fp_stat_o);
	gpr_model gpr_u (.clk_i, .instr_i, .wr_valid_i(wr_valid_o), .wr_sel_i(wr_sel_o), .wr_data_i(wr_data_o),
		.first_o(a_w), .second_o(b_w), .target_o(t_w));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	// operands come from registers 5 and 4, the result goes to register 6
	task automatic issue(input logic [31:0] ins);
		@(posedge clk_i);
		{instr_valid_i, instr_i} <= {1'b1, ins};
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1 n_ops++;
	endtask
	function automatic logic [31:0] gen_mask(input logic [4:0] s, input logic [4:0] e);
		logic [31:0] m;
		for (int p = 0; p < 32; p++)
			m[31 - p] = (s <= e) ? (p >= s && p <= e) : !(p > e && p < s);
		return m;
	endfunction
	function automatic logic [3:0] sign_flags(input logic [31:0] r, input logic so);
		return {r[31], !r[31] && r != 0, r == 0, so};
	endfunction
	task automatic results();
		$display("%0d checks, %0d miscompares", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			if (i > 4)
				bus(1'b1, 8'(4 * i - 8), 32'hFFFF_FFFF);
			bus(1'b0, 8'(4 * i - (i > 4 ? 8 : 0)), 32'h0);
			check(q, 32'h0);
		end
		$display("register test done");
		cr = 32'h0;
		for (int k = 0; k < 60; k++)
		begin
			a = $random(seed);
			b = $random(seed);
			if (k < 4)
				{a, b} = {32'h10, 32'h14, 32'h17, 32'h10, 32'h0, 32'h1F, 32'h1F, 32'h0} >> (192 - 64 * k);
			if (k == 4)
				bus(1'b1, mask_cr_pkg::OFS_FX_EXC, 32'h8000_0000);
			{gpr_u.regs[5], gpr_u.regs[4]} = {a, b};
			g = gen_mask(a[4:0], b[4:0]);
			issue({mask_cr_pkg::OP_FIXED, 15'h14C4, mask_cr_pkg::XO_MASK_GEN, k[0]});
			check(wr_data_o, g);
			check(wr_sel_o, 32'd6);
			if (k[0])
				cr[31:28] = sign_flags(g, k >= 4);
			check(cond_reg_o, cr);
			issue({mask_cr_pkg::OP_FIXED, 15'h14C4, mask_cr_pkg::XO_MASK_INS, k[1]});
			g = (a & b) | (g & ~b);
			check(wr_data_o, g);
			if (k[1])
				cr[31:28] = sign_flags(g, k >= 4);
			check(cond_reg_o, cr);
		end
		bus(1'b0, mask_cr_pkg::OFS_FX_EXC, 32'h0);
		check(q, 32'h8000_0000);
		$display("mask test done");
		for (int k = 0; k < 32; k++)
		begin
			{cr, fs, d} = {$random(seed), $random(seed), 3'($random(seed))};
			bus(1'b1, mask_cr_pkg::OFS_COND_REG, cr);
			bus(1'b1, mask_cr_pkg::OFS_FP_STAT, fs);
			issue({k[0] ? mask_cr_pkg::OP_FLOAT : mask_cr_pkg::OP_COND, d, 2'b0, 3'(k / 2), 7'h00,
				k[0] ? mask_cr_pkg::XO_FS_COPY : mask_cr_pkg::XO_CR_COPY, 1'b0});
			g = k[0] ? fs & ~mask_cr_pkg::FS_RESERVED : cr;
			cr[31 - 4 * d -: 4] = 4'(g >> (28 - 4 * (k / 2 % 8)));
			check(cond_reg_o, cr);
			check(fp_stat_o, k[0] ? fs & ~mask_cr_pkg::FS_CLEAR[k / 2 % 8] : fs);
		end
		$display("field copy test done");
		issue(32'h0);
		check(illegal_o, 32'h1);
		bus(1'b0, mask_cr_pkg::OFS_OP_COUNT, 32'h0);
		check(q, 32'(n_ops));
		$display("count test done");
		results();
	end
	initial
	begin
		#50000;
		miscompares++;
		results();
	end
endmodule
